// ---- prf_pkg.sv ----
// Shared constants and types of the linear ramp pulse profiler
package prf_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPD_W  = 16;
  localparam int FRAC_W = 16;
  localparam int CNT_W  = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_MODE   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_EXT6   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CMD    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RANGE  = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ACCEL  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DECEL  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_INIT   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_DRIVE  = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_PULSES = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OFFSET = 8'h24;
  localparam logic [ADDR_W-1:0] REG_DPOINT = 8'h28;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_SPEED  = 8'h30;
  localparam logic [ADDR_W-1:0] REG_REMAIN = 8'h34;
  localparam logic [ADDR_W-1:0] REG_ACNT   = 8'h38;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_MANUAL_BIT = 0;
  localparam int MODE_SEP_BIT    = 1;
  localparam int MODE_SCURVE_BIT = 2;
  localparam int EXT_TRI_BIT     = 3;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DEC_POINT = 8'h07;
  localparam logic [7:0] CMD_FIXED     = 8'h20;
  localparam logic [7:0] CMD_CONT      = 8'h22;
  localparam logic [7:0] CMD_DEC_STOP  = 8'h26;
  localparam logic [7:0] CMD_SUDDEN    = 8'h27;
  localparam logic [7:0] CMD_EXT_MODE  = 8'h60;

  // ----------------------------------------------------------------
  // Reset values, responses, timing
  // ----------------------------------------------------------------
  localparam logic [15:0] OFFSET_RST  = 16'h0008;
  localparam logic [31:0] RANGE_RST   = 32'h007a1200;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam int          ACC_DIV_DEF = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCEL, ST_CONST, ST_DECEL}
    prf_state_t;

endpackage : prf_pkg

// ---- prf_pulse_if.sv ----
// Link between the ramp controller and the pulse generator
`timescale 1ns/1ps
interface prf_pulse_if;
  logic        run;
  logic [15:0] speed;
  logic [31:0] range;
  logic        pulse;

  modport gen (input run, input speed, input range, output pulse);
  modport ctl (output run, output speed, output range, input pulse);
endinterface : prf_pulse_if

// ---- prf_pulse_gen.sv ----
// Phase accumulator that turns a speed value into drive pulses
`timescale 1ns/1ps
module prf_pulse_gen (
  input  wire logic aclk,
  input  wire logic aresetn,
  prf_pulse_if.gen  link
);
  import prf_pkg::*;

  logic [32:0] acc_q;
  logic        pulse_q;
  wire  [32:0] sum  = acc_q + 33'(link.speed);
  wire         wrap = (link.range != 32'h0000_0000) &&
                      (sum >= {1'b0, link.range});

  // Pulse rate is speed * f_clk / range; range scales the speed unit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !link.run)
    begin
      acc_q   <= 33'h0_0000_0000;
      pulse_q <= 1'b0;
    end
    else
    begin
      acc_q   <= wrap ? (sum - {1'b0, link.range}) : sum;
      pulse_q <= wrap;
    end
  end

  assign link.pulse = pulse_q;

endmodule : prf_pulse_gen

// ---- prf_linear_ramp.sv ----
// Linear ramp pulse profiler: AXI4-Lite registers and ramp control
// Functional notes
// - Accelerate linearly from initial to drive speed
// - Count pulses emitted while accelerating
// - Decelerate when remaining below acceleration pulses
// - Decelerate to initial speed, stop at count
// - Stop command or short count gives triangle
// - Symmetric mode uses acceleration for deceleration
// - Continuous driving ignores the pulse count
// - Triangle guard holds speed past half count
// - Triangle guard off at reset, set by 60h
// - Non-symmetric deceleration point computed internally
// - Separate bit selects deceleration slope value with manual and S-curve bits clear
// - Large A/D ratio adds creep pulses
// - Drive below initial speed means constant speed
// - Manual bit uses preset deceleration point
// - Offset resets to eight, shifts deceleration point
`timescale 1ns/1ps
module prf_linear_ramp #(
  parameter int ACC_DIV = prf_pkg::ACC_DIV_DEF
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [prf_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output      logic                        s_axi_awready,
  input  wire logic [prf_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output      logic                        s_axi_wready,
  output      logic [1:0]                  s_axi_bresp,
  output      logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [prf_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output      logic                        s_axi_arready,
  output      logic [prf_pkg::DATA_W-1:0]  s_axi_rdata,
  output      logic [1:0]                  s_axi_rresp,
  output      logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output      logic                        pulse_out,
  output      logic                        drive_busy
);
  import prf_pkg::*;

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  logic              aw_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              w_held_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_ok = (awaddr_q[1:0] == 2'b00) && (awaddr_q <= REG_DPOINT);
  wire wr_en = wr_fire & wr_ok;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (aw_take)
    begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end
    else if (w_take)
    begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [2:0]  mode_reg_three_q;
  logic [7:0]  ext_data_word_six_q;
  logic [31:0] range_q;
  logic [15:0] accel_q;
  logic [15:0] decel_q;
  logic [15:0] init_q;
  logic [15:0] drive_q;
  logic [31:0] pulses_q;
  logic [15:0] offset_q;
  logic [31:0] dpoint_reg_q;

  wire sel_cmd = wr_en && (awaddr_q == REG_CMD) && wstrb_q[0];
  wire [7:0] cmd_code = wdata_q[7:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg_three_q    <= 3'h0;
      ext_data_word_six_q <= 8'h00;
      range_q             <= RANGE_RST;
      accel_q             <= 16'h0000;
      decel_q             <= 16'h0000;
      init_q              <= 16'h0000;
      drive_q             <= 16'h0000;
      pulses_q            <= 32'h0000_0000;
      offset_q            <= OFFSET_RST;
      dpoint_reg_q        <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      unique case (awaddr_q)
        REG_MODE:   mode_reg_three_q <= (mode_reg_three_q & ~wmask[2:0]) |
                                        (wdata_q[2:0] & wmask[2:0]);
        REG_EXT6:   ext_data_word_six_q <= (ext_data_word_six_q &
                                            ~wmask[7:0]) |
                                           (wdata_q[7:0] & wmask[7:0]);
        REG_RANGE:  range_q <= (range_q & ~wmask) | (wdata_q & wmask);
        REG_ACCEL:  accel_q <= (accel_q & ~wmask[15:0]) |
                               (wdata_q[15:0] & wmask[15:0]);
        REG_DECEL:  decel_q <= (decel_q & ~wmask[15:0]) |
                               (wdata_q[15:0] & wmask[15:0]);
        REG_INIT:   init_q <= (init_q & ~wmask[15:0]) |
                              (wdata_q[15:0] & wmask[15:0]);
        REG_DRIVE:  drive_q <= (drive_q & ~wmask[15:0]) |
                               (wdata_q[15:0] & wmask[15:0]);
        REG_PULSES: pulses_q <= (pulses_q & ~wmask) | (wdata_q & wmask);
        REG_OFFSET: offset_q <= (offset_q & ~wmask[15:0]) |
                                (wdata_q[15:0] & wmask[15:0]);
        REG_DPOINT: dpoint_reg_q <= (dpoint_reg_q & ~wmask) |
                                    (wdata_q & wmask);
        default:    ;
      endcase
    end
  end

  // Commands latch the working copies of the guard and manual point
  logic        tri_en_q;
  logic [31:0] man_point_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tri_en_q    <= 1'b0;
      man_point_q <= 32'h0000_0000;
    end
    else if (sel_cmd)
    begin
      if (cmd_code == CMD_EXT_MODE)
        tri_en_q <= ext_data_word_six_q[EXT_TRI_BIT];
      if (cmd_code == CMD_DEC_POINT)
        man_point_q <= dpoint_reg_q;
    end
  end

  // ----------------------------------------------------------------
  // Ramp decisions
  // ----------------------------------------------------------------
  prf_state_t  state_q, state_d;
  logic [31:0] spd_q, spd_d;
  logic [31:0] rem_q, rem_d;
  logic [31:0] acnt_q, acnt_d;
  logic [31:0] total_q, total_d;
  logic        fixed_q, fixed_d;
  logic        stop_q, stop_d;
  logic [15:0] div_q;

  prf_pulse_if link ();

  wire manual_decel_select   = mode_reg_three_q[MODE_MANUAL_BIT];
  wire separate_decel_enable = mode_reg_three_q[MODE_SEP_BIT];
  // S-curve is not built here; that bit falls back to linear ramps
  wire s_curve_select        = mode_reg_three_q[MODE_SCURVE_BIT];
  wire linear_auto = ~manual_decel_select & ~s_curve_select;

  wire [15:0] d_eff = (separate_decel_enable && linear_auto) ?
                      decel_q : accel_q;

  wire [31:0] spd_init  = {init_q, 16'h0000};
  wire [31:0] spd_drive = {drive_q, 16'h0000};
  wire        no_ramp   = (drive_q <= init_q);

  wire [49:0] rem_prod  = 50'(rem_q) * 50'(d_eff);
  wire [49:0] acnt_prod = 50'(acnt_q) * 50'(accel_q);
  wire signed [49:0] off_prod = 50'($signed(offset_q) *
                                    $signed({1'b0, d_eff}));
  wire signed [49:0] dec_lim  = $signed(acnt_prod) + off_prod;
  wire auto_hit   = $signed(rem_prod) < dec_lim;
  wire manual_hit = rem_q <= man_point_q;
  wire dec_hit    = manual_decel_select ? manual_hit : auto_hit;

  wire [49:0] tri_lhs = 50'(acnt_q) * 50'({1'b0, accel_q} +
                                          {1'b0, d_eff});
  wire [49:0] tri_rhs = 50'(total_q[31:1]) * 50'(d_eff);
  wire tri_hit = tri_en_q & ~manual_decel_select & (tri_lhs > tri_rhs);

  wire tick  = (div_q == 16'(ACC_DIV - 1));
  wire pulse = link.pulse;
  wire start_fixed = sel_cmd && (cmd_code == CMD_FIXED) &&
                     (pulses_q != 32'h0000_0000);
  wire start_cont  = sel_cmd && (cmd_code == CMD_CONT);
  wire cmd_dstop   = sel_cmd && (cmd_code == CMD_DEC_STOP);
  wire cmd_sudden  = sel_cmd && (cmd_code == CMD_SUDDEN);

  wire [31:0] spd_up = spd_q + 32'(accel_q);
  wire [31:0] spd_dn = spd_q - 32'(d_eff);
  wire        at_floor = (spd_q <= spd_init + 32'(d_eff));

  always_comb
  begin
    state_d = state_q;
    spd_d   = spd_q;
    rem_d   = rem_q;
    acnt_d  = acnt_q;
    total_d = total_q;
    fixed_d = fixed_q;
    stop_d  = stop_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start_fixed || start_cont)
        begin
          fixed_d = start_fixed;
          stop_d  = 1'b0;
          acnt_d  = 32'h0000_0000;
          rem_d   = pulses_q;
          total_d = pulses_q;
          spd_d   = no_ramp ? spd_drive : spd_init;
          state_d = no_ramp ? ST_CONST : ST_ACCEL;
        end
      end
      ST_ACCEL:
      begin
        if (tick)
        begin
          if (spd_up >= spd_drive)
          begin
            spd_d   = spd_drive;
            state_d = ST_CONST;
          end
          else
            spd_d = spd_up;
        end
        if (pulse)
          acnt_d = acnt_q + 32'h0000_0001;
        if (pulse && fixed_q && tri_hit)
          state_d = ST_CONST;
        if (pulse && fixed_q && dec_hit)
          state_d = ST_DECEL;
      end
      ST_CONST:
      begin
        if (pulse && fixed_q && dec_hit && !no_ramp)
          state_d = ST_DECEL;
      end
      ST_DECEL:
      begin
        if (tick)
        begin
          if (at_floor)
          begin
            spd_d = spd_init;
            if (stop_q || !fixed_q)
              state_d = ST_IDLE;
          end
          else
            spd_d = spd_dn;
        end
      end
    endcase
    if (cmd_dstop && state_q != ST_IDLE)
    begin
      stop_d  = 1'b1;
      state_d = no_ramp ? ST_IDLE : ST_DECEL;
    end
    if (pulse && fixed_q && state_q != ST_IDLE)
    begin
      rem_d = rem_q - 32'h0000_0001;
      if (rem_q == 32'h0000_0001)
        state_d = ST_IDLE;
    end
    if (cmd_sudden)
      state_d = ST_IDLE;
  end

  // ----------------------------------------------------------------
  // Ramp state and acceleration tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      spd_q   <= 32'h0000_0000;
      rem_q   <= 32'h0000_0000;
      acnt_q  <= 32'h0000_0000;
      total_q <= 32'h0000_0000;
      fixed_q <= 1'b0;
      stop_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      spd_q   <= spd_d;
      rem_q   <= rem_d;
      acnt_q  <= acnt_d;
      total_q <= total_d;
      fixed_q <= fixed_d;
      stop_q  <= stop_d;
    end
  end

  // Slope is counted in 1/65536 speed units per tick of this divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  assign link.run   = (state_q != ST_IDLE);
  assign link.speed = spd_q[31:16];
  assign link.range = range_q;

  prf_pulse_gen u_gen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link    (link)
  );

  assign pulse_out  = link.pulse;
  assign drive_busy = link.run;

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire [31:0] status_word = {27'h0, tri_en_q, state_q == ST_DECEL,
                             state_q == ST_CONST, state_q == ST_ACCEL,
                             link.run};

  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      REG_MODE:   rd_data = {29'h0, mode_reg_three_q};
      REG_EXT6:   rd_data = {24'h0, ext_data_word_six_q};
      REG_RANGE:  rd_data = range_q;
      REG_ACCEL:  rd_data = {16'h0, accel_q};
      REG_DECEL:  rd_data = {16'h0, decel_q};
      REG_INIT:   rd_data = {16'h0, init_q};
      REG_DRIVE:  rd_data = {16'h0, drive_q};
      REG_PULSES: rd_data = pulses_q;
      REG_OFFSET: rd_data = {16'h0, offset_q};
      REG_DPOINT: rd_data = dpoint_reg_q;
      REG_STATUS: rd_data = status_word;
      REG_SPEED:  rd_data = {16'h0, spd_q[31:16]};
      REG_REMAIN: rd_data = rem_q;
      REG_ACNT:   rd_data = acnt_q;
      REG_CMD:    rd_data = 32'h0000_0000;
      default:
      begin
        rd_data = 32'h0000_0000;
        rd_ok   = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule : prf_linear_ramp

// ---- prf_linear_ramp_sva.sv ----
// Concurrent checks on the profiler's bus and pulse ports
`timescale 1ns/1ps
module prf_linear_ramp_sva (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic [prf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       pulse_out,
  input wire logic                       drive_busy
);
  import prf_pkg::*;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready high while a response waits");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("wready high while a response waits");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while read data waits");
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read data late");
  b_release_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("bvalid dropped without bready");
  r_release_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("rvalid dropped without rready");
  rresp_err_a: assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr > REG_ACNT || s_axi_araddr[1:0] != 2'b00)
    |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  pulse_width_a: assert property (pulse_out |=> !pulse_out)
    else $error("drive pulse longer than one cycle");
  idle_quiet_a: assert property (!drive_busy && !$past(drive_busy)
    |-> !pulse_out)
    else $error("pulse while no drive runs");

  cover property ($rose(drive_busy));
  cover property ($fell(drive_busy));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : prf_linear_ramp_sva

bind prf_linear_ramp prf_linear_ramp_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp),
  .pulse_out(pulse_out), .drive_busy(drive_busy)
);

// ---- prf_motor_model.sv ----
// Motor driver stand-in that counts pulses and times their spacing
`timescale 1ns/1ps
module prf_motor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step,
  input wire logic enable,
  output logic [31:0] count,
  output logic [31:0] first_gap,
  output logic [31:0] min_gap,
  output logic [31:0] max_gap,
  output logic [31:0] last_gap
);
  logic [31:0] gap_q;
  logic        en_q;

  // Statistics restart with each drive so every run is judged alone
  always_ff @(posedge aclk)
  begin
    en_q <= enable;
    if (!aresetn || (enable && !en_q))
    begin
      count <= '0;
      gap_q <= '0;
      first_gap <= '0;
      min_gap <= '1;
      max_gap <= '0;
      last_gap <= '0;
    end
    else if (step)
    begin
      count <= count + 1;
      gap_q <= 32'h1;
      if (count == 32'h1)
        first_gap <= gap_q;
      if (count != 32'h0)
      begin
        last_gap <= gap_q;
        if (gap_q < min_gap)
          min_gap <= gap_q;
        if (gap_q > max_gap)
          max_gap <= gap_q;
      end
    end
    else
      gap_q <= gap_q + 1;
  end
endmodule : prf_motor_model

// ---- prf_linear_ramp_tb_top.sv ----
// Random and directed bench for the linear ramp profiler
`timescale 1ns/1ps
module prf_linear_ramp_tb_top;
  import prf_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              pulse_out, drive_busy;
  logic [1:0]        bresp, rresp, r;
  logic [DATA_W-1:0] rdata;
  logic [31:0]       cnt, gap0, gmin, gmax, glast, v, tri_min;
  logic [31:0]       rng = 32'hab77;
  logic [7:0]        bad [3] = '{8'h3c, 8'h06, 8'hfc};
  int                n_mismatch = 0;
  int                checks = 0;

  always #2 aclk = ~aclk;

  prf_linear_ramp #(.ACC_DIV(1)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pulse_out(pulse_out), .drive_busy(drive_busy));

  prf_motor_model motor (
    .aclk(aclk), .aresetn(aresetn), .step(pulse_out), .enable(drive_busy),
    .count(cnt), .first_gap(gap0), .min_gap(gmin), .max_gap(gmax),
    .last_gap(glast));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [1:0] exp_resp(input logic [7:0] a);
    return (a[1:0] != 2'b00 || a > REG_ACNT) ? RESP_SLVERR : RESP_OKAY;
  endfunction : exp_resp

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("write response", er, bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rr);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    rr = rresp;
  endtask : rd

  task automatic drive(input logic [31:0] m, input logic [31:0] acc,
                       input logic [31:0] dec, input logic [31:0] sv,
                       input logic [31:0] dv, input logic [31:0] n);
    wr(REG_MODE, m, RESP_OKAY);
    wr(REG_ACCEL, acc, RESP_OKAY);
    wr(REG_DECEL, dec, RESP_OKAY);
    wr(REG_INIT, sv, RESP_OKAY);
    wr(REG_DRIVE, dv, RESP_OKAY);
    wr(REG_PULSES, n, RESP_OKAY);
    wr(REG_CMD, {24'h0, CMD_FIXED}, RESP_OKAY);
    repeat (2) @(posedge aclk);
    while (drive_busy)
      @(posedge aclk);
    @(posedge aclk);
    chk("pulse count", n, cnt);
  endtask : drive

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_OFFSET, v, r);
    chk("offset reset", {16'h0, OFFSET_RST}, v);
    rd(REG_RANGE, v, r);
    chk("range reset", RANGE_RST, v);
    rd(REG_STATUS, v, r);
    chk("guard at reset", 1'b0, v[4]);
    for (int i = 0; i < 3; i++)
    begin
      rd(bad[i], v, r);
      chk("read response", exp_resp(bad[i]), r);
      wr(bad[i], 32'h0, exp_resp(bad[i]));
    end
    wr(REG_SPEED, 32'h1, RESP_SLVERR);
    wr(REG_RANGE, 32'h1000, RESP_OKAY);
    // Mode bits clear, decel value unused
    drive(0, 32'h4000, 32'h100, 100, 1000, 1500);
    chk("ramp up", 1'b1, gmin < gap0);
    chk("ramp down", 1'b1, glast * 2 > gap0);
    rd(REG_ACNT, v, r);
    chk("accel pulses", 1'b1, v > 0 && v < 750);
    drive(0, 32'h4000, 32'h4000, 100, 1000, 200);
    tri_min = gmin;
    chk("triangle end", 1'b1, glast * 2 > gap0);
    wr(REG_EXT6, 32'h1 << EXT_TRI_BIT, RESP_OKAY);
    wr(REG_CMD, {24'h0, CMD_EXT_MODE}, RESP_OKAY);
    rd(REG_STATUS, v, r);
    chk("guard on", 1'b1, v[4]);
    drive(0, 32'h4000, 32'h4000, 100, 1000, 200);
    chk("guard caps speed", 1'b1, gmin > tri_min);
    wr(REG_EXT6, 32'h0, RESP_OKAY);
    wr(REG_CMD, {24'h0, CMD_EXT_MODE}, RESP_OKAY);
    // Decel above accel keeps ratio legal
    drive(32'h2, 32'h4000, 32'hc000, 100, 1000, 1500);
    chk("own slope", 1'b1, glast * 2 > gap0);
    drive(0, 32'h4000, 32'h4000, 800, 400, 100);
    chk("flat rate", 1'b1, gmax - gmin <= 1);
    wr(REG_DPOINT, 32'd50, RESP_OKAY);
    wr(REG_CMD, {24'h0, CMD_DEC_POINT}, RESP_OKAY);
    drive(32'h1, 32'h4000, 32'h4000, 100, 1000, 600);
    wr(REG_MODE, 32'h0, RESP_OKAY);
    wr(REG_PULSES, 32'h0, RESP_OKAY);
    wr(REG_CMD, {24'h0, CMD_CONT}, RESP_OKAY);
    repeat (500) @(posedge aclk);
    chk("continuous", 1'b1, drive_busy);
    wr(REG_CMD, {24'h0, CMD_DEC_STOP}, RESP_OKAY);
    while (drive_busy)
      @(posedge aclk);
    @(posedge aclk);
    chk("stop in accel", 1'b1, glast * 2 > gap0);
    wr(REG_CMD, {24'h0, CMD_CONT}, RESP_OKAY);
    repeat (100) @(posedge aclk);
    wr(REG_CMD, {24'h0, CMD_SUDDEN}, RESP_OKAY);
    @(posedge aclk);
    #1;
    chk("sudden stop", 1'b0, drive_busy);
    for (int i = 0; i < 3; i++)
    begin
      rng = xs(rng);
      drive({29'h0, i[0], rng[0], 1'b0}, 32'h2000 + rng[14:1],
            32'h2000 + rng[28:15], 100, 1000, 200 + rng[31:23]);
    end
    end_of_test();
  end

  initial
  begin
    repeat (95000) @(posedge aclk);
    n_mismatch++;
    end_of_test();
  end
endmodule : prf_linear_ramp_tb_top
